// ===== hw/stsp_buf.sv
// Two-entry skid buffer on the transmit word path
`timescale 1ns/1ps
`default_nettype none
module stsp_buf #(
   parameter int W = 18
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   stsp_stream_if.snk in_if,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [W-1:0] out_q, out_d, skid_q, skid_d;
   logic out_v_q, out_v_d, skid_v_q, skid_v_d, in_fire;

   // Ready comes from a flop so the source never sees a combinational path
   assign in_if.ready = ~skid_v_q;
   assign out_data = out_q;
   assign out_valid = out_v_q;

   always_comb begin
      out_d = out_q;
      out_v_d = out_v_q;
      skid_d = skid_q;
      skid_v_d = skid_v_q;
      in_fire = in_if.valid & ~skid_v_q;
      if (!out_v_q || out_ready) begin
         if (skid_v_q) begin
            out_d = skid_q;
            out_v_d = 1'b1;
            skid_v_d = 1'b0;
         end else begin
            out_v_d = in_fire;
            if (in_fire) begin
               out_d = in_if.data;
            end
         end
      end else if (in_fire) begin
         skid_d = in_if.data;
         skid_v_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= '0;
         out_v_q <= 1'b0;
         skid_q <= '0;
         skid_v_q <= 1'b0;
      end else if (ce) begin
         out_q <= out_d;
         out_v_q <= out_v_d;
         skid_q <= skid_d;
         skid_v_q <= skid_v_d;
      end
   end

   c_buf_full: cover property (@(posedge clk) disable iff (!rstn)
      out_v_q && skid_v_q && !out_ready);
endmodule : stsp_buf
`default_nettype wire

// ===== hw/stsp_port.sv
// System-side channel port, control channel and interrupt of the transceiver
// Notes on behaviour
// - B and D channel bits shift at the bit clock rate.
// - An input bit clock needs no relation to the core clock; sampled.
// - Terminal master drives the bit clock at the format's frequency.
// - Terminal master locks bit clock phase to the line frame.
// - Terminal master outputs a frame sync pulse starting both directions.
// - Status output is driven only while chip select is low.
// - Control channel shifts only with chip select low; else ignored.
// - Interrupt is open drain, latched until cleared.
// - Line side is full duplex 192 kb/s on separate pairs.
// - Frame word carries two 8-bit B channels and a 2-bit D channel.
// - S1, S2 and Q maintenance bits are also carried.
// - After reset enhanced features are off until firmware enables them.
// - Mode selects terminal master or slave, network end or line card.
// - Receive data follows bit clock and floats when not shifting.
// - Terminal master pulses the D window high over D transmit bits.
`timescale 1ns/1ps
`default_nettype none
module stsp_port import stsp_pkg::*; (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [1:0] MODE,
   input wire logic [1:0] FORMAT,
   input wire logic LINE_FRAME,
   input wire logic LINE_EVENT,
   input wire logic [2:0] MAINT_IN,
   input wire logic BCLK_I,
   output logic BCLK_O,
   output logic BCLK_OE,
   input wire logic TX_FRAME_SYNC_I,
   output logic TX_FRAME_SYNC_O,
   output logic TX_FRAME_SYNC_OE,
   input wire logic RX_FRAME_SYNC_I,
   input wire logic TX_CHAN_DATA_IN,
   output logic RX_CHAN_DATA_OUT,
   output logic RX_CHAN_DATA_OE,
   output logic D_CHAN_TX_WINDOW,
   input wire logic CS_N,
   input wire logic CTL_SHIFT_CLOCK,
   input wire logic CTL_DATA_IN,
   output logic STATUS_SHIFT_OUTPUT,
   output logic STATUS_SHIFT_OE,
   output logic INT_N_O,
   output logic INT_N_OE,
   output logic [WORD_W-1:0] TX_WORD,
   output logic TX_VALID,
   input wire logic TX_READY,
   input wire logic [WORD_W-1:0] RX_WORD,
   input wire logic RX_VALID,
   output logic RX_READY,
   output logic TX_OVERRUN,
   output logic ENH_ACTIVE,
   output logic [CTL_W-1:0] CTL_CMD,
   output logic CTL_CMD_VALID
);
   // ==========================================================
   // Pin synchronisers: a change counts once stages two and three agree
   logic [NSYNC-1:0] pins, s1_q, s2_q, s3_q, lvl_q, lvl_d, rise, fall;
   assign pins = {CTL_DATA_IN, CTL_SHIFT_CLOCK, CS_N, TX_CHAN_DATA_IN,
                  RX_FRAME_SYNC_I, TX_FRAME_SYNC_I, BCLK_I};

   always_comb begin
      lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      rise = lvl_d & ~lvl_q;
      fall = ~lvl_d & lvl_q;
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         lvl_q <= SYNC_RST;
      end else if (CE) begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   // ==========================================================
   // Bit clock, frame position and D window
   stsp_mode_t mode_q;
   stsp_fmt_t fmt_q;
   logic [7:0] div_q, div_d, fcnt_q, fcnt_d, pos;
   logic bclk_q, bclk_d, fs_q, fs_d, dwin_q, dwin_d, bclk_oe_q;
   logic master, dwin_en, bit_rise, bit_fall, frame_tx, frame_rx;
   logic enh_q;
   logic [4:0] tx_cnt_d;

   always_comb begin
      master = (mode_q == MODE_TE_MASTER);
      dwin_en = master | enh_q;
      div_d = div_q;
      bclk_d = 1'b0;
      fcnt_d = fcnt_q;
      bit_rise = rise[P_BCLK];
      bit_fall = fall[P_BCLK];
      if (master) begin
         bclk_d = bclk_q;
         bit_rise = 1'b0;
         bit_fall = 1'b0;
         if (LINE_FRAME) begin
            div_d = 8'h00;
            bclk_d = 1'b0;
            fcnt_d = fmt_last(fmt_q);
         end else if (div_q == fmt_half(fmt_q)) begin
            div_d = 8'h00;
            bclk_d = ~bclk_q;
            bit_rise = ~bclk_q;
            bit_fall = bclk_q;
         end else begin
            div_d = div_q + 8'h01;
         end
         if (bit_rise) begin
            fcnt_d = (fcnt_q == fmt_last(fmt_q)) ? 8'h00 : fcnt_q + 8'h01;
         end
      end
      frame_tx = master ? (bit_rise && fcnt_d == 8'h00) : rise[P_TXFS];
      frame_rx = master ? frame_tx : rise[P_RXFS];
      fs_d = master & fs_q;
      if (master && bit_rise) begin
         fs_d = (fcnt_d == 8'h00);
      end
      pos = master ? fcnt_d : {3'h0, tx_cnt_d};
      dwin_d = dwin_en & dwin_q;
      if (bit_rise) begin
         dwin_d = dwin_en && pos >= D_FIRST && pos < D_END;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_q <= MODE_TE_MASTER;
         fmt_q <= FMT_2048;
         div_q <= 8'h00;
         bclk_q <= 1'b0;
         fcnt_q <= 8'h00;
         fs_q <= 1'b0;
         dwin_q <= 1'b0;
         bclk_oe_q <= 1'b0;
      end else if (CE) begin
         mode_q <= stsp_mode_t'(MODE);
         fmt_q <= stsp_fmt_t'(FORMAT);
         div_q <= div_d;
         bclk_q <= bclk_d;
         fcnt_q <= fcnt_d;
         fs_q <= fs_d;
         dwin_q <= dwin_d;
         // Drive only when stored and incoming mode agree: no contention
         // with a slave-side clock in the first cycle after reset
         bclk_oe_q <= master && stsp_mode_t'(MODE) == MODE_TE_MASTER;
      end
   end

   assign BCLK_O = bclk_q;
   assign BCLK_OE = bclk_oe_q;
   assign TX_FRAME_SYNC_O = fs_q;
   assign TX_FRAME_SYNC_OE = bclk_oe_q;
   assign D_CHAN_TX_WINDOW = dwin_q;

   // ==========================================================
   // Transmit: sample on bit clock fall, hand words to the buffer
   stsp_stream_if #(.W(WORD_W)) tx_if ();
   logic [4:0] tx_cnt_q;
   logic [WORD_W-1:0] tx_sh_q, tx_sh_d, tx_word_q, tx_word_d;
   logic tx_pend_q, tx_pend_d, ovr_q, ovr_d, tx_done, ovr_evt, clr;

   always_comb begin
      tx_cnt_d = tx_cnt_q;
      tx_sh_d = tx_sh_q;
      tx_word_d = tx_word_q;
      tx_done = 1'b0;
      ovr_evt = 1'b0;
      if (frame_tx) begin
         tx_cnt_d = 5'h00;
      end else if (bit_fall && tx_cnt_q < WORD_BITS) begin
         tx_sh_d = {tx_sh_q[WORD_W-2:0], lvl_d[P_TXD]};
         tx_cnt_d = tx_cnt_q + 5'h01;
         tx_done = (tx_cnt_q == LAST_BIT);
      end
      tx_pend_d = tx_pend_q & ~tx_if.ready;
      // A full buffer drops the new word, never the queued one
      if (tx_done) begin
         if (tx_pend_d) begin
            ovr_evt = 1'b1;
         end else begin
            tx_word_d = tx_sh_d;
            tx_pend_d = 1'b1;
         end
      end
      ovr_d = (ovr_q & ~clr) | ovr_evt;
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_cnt_q <= WORD_BITS;
         tx_sh_q <= '0;
         tx_word_q <= '0;
         tx_pend_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (CE) begin
         tx_cnt_q <= tx_cnt_d;
         tx_sh_q <= tx_sh_d;
         tx_word_q <= tx_word_d;
         tx_pend_q <= tx_pend_d;
         ovr_q <= ovr_d;
      end
   end

   assign tx_if.data = tx_word_q;
   assign tx_if.valid = tx_pend_q;
   assign TX_OVERRUN = ovr_q;

   stsp_buf #(.W(WORD_W)) u_txbuf (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .ce(CE),
      .in_if(tx_if),
      .out_data(TX_WORD),
      .out_valid(TX_VALID),
      .out_ready(TX_READY)
   );

   // ==========================================================
   // Receive: one word per frame, shifted out on bit clock rise
   logic [WORD_W-1:0] rx_hold_q, rx_hold_d, rx_sh_q, rx_sh_d, rx_w;
   logic [4:0] rx_cnt_q, rx_cnt_d;
   logic rx_full_q, rx_full_d, rx_out_q, rx_out_d, rx_oe_q, rx_oe_d;
   logic rx_rdy_q;

   always_comb begin
      rx_hold_d = rx_hold_q;
      rx_full_d = rx_full_q;
      rx_sh_d = rx_sh_q;
      rx_cnt_d = rx_cnt_q;
      rx_out_d = rx_out_q;
      rx_oe_d = rx_oe_q;
      // An empty holding register sends idle ones
      rx_w = rx_full_q ? rx_hold_q : IDLE_WORD;
      if (frame_rx) begin
         rx_full_d = 1'b0;
         rx_out_d = rx_w[WORD_W-1];
         rx_sh_d = {rx_w[WORD_W-2:0], 1'b0};
         rx_cnt_d = 5'h01;
         rx_oe_d = 1'b1;
      end else if (bit_rise) begin
         if (rx_cnt_q < WORD_BITS) begin
            rx_out_d = rx_sh_q[WORD_W-1];
            rx_sh_d = {rx_sh_q[WORD_W-2:0], 1'b0};
            rx_cnt_d = rx_cnt_q + 5'h01;
         end else begin
            rx_oe_d = 1'b0;
         end
      end
      if (RX_VALID && rx_rdy_q) begin
         rx_hold_d = RX_WORD;
         rx_full_d = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_hold_q <= '0;
         rx_full_q <= 1'b0;
         rx_sh_q <= '0;
         rx_cnt_q <= WORD_BITS;
         rx_out_q <= 1'b0;
         rx_oe_q <= 1'b0;
         rx_rdy_q <= 1'b0;
      end else if (CE) begin
         rx_hold_q <= rx_hold_d;
         rx_full_q <= rx_full_d;
         rx_sh_q <= rx_sh_d;
         rx_cnt_q <= rx_cnt_d;
         rx_out_q <= rx_out_d;
         rx_oe_q <= rx_oe_d;
         rx_rdy_q <= ~rx_full_d;
      end
   end

   assign RX_CHAN_DATA_OUT = rx_out_q;
   assign RX_CHAN_DATA_OE = rx_oe_q;
   assign RX_READY = rx_rdy_q;

   // ==========================================================
   // Control channel, enhanced-mode enable and latched interrupt
   logic [3:0] ctl_cnt_q, ctl_cnt_d;
   logic [CTL_W-1:0] ctl_in_q, ctl_in_d, st_sh_q, st_sh_d, cmd_q, cmd_d;
   logic [CTL_W-1:0] stat;
   logic st_out_q, st_out_d, st_oe_q, st_oe_d, cmd_v_q, cmd_v_d;
   logic enh_d, int_q, int_d;

   always_comb begin
      ctl_cnt_d = ctl_cnt_q;
      ctl_in_d = ctl_in_q;
      st_sh_d = st_sh_q;
      st_out_d = st_out_q;
      st_oe_d = st_oe_q;
      cmd_d = cmd_q;
      cmd_v_d = 1'b0;
      enh_d = enh_q;
      clr = 1'b0;
      stat = {enh_q, int_q, ovr_q, MAINT_IN, mode_q};
      if (fall[P_CS]) begin
         ctl_cnt_d = 4'h0;
         st_out_d = stat[CTL_W-1];
         st_sh_d = {stat[CTL_W-2:0], 1'b0};
         st_oe_d = 1'b1;
      end else if (lvl_q[P_CS]) begin
         ctl_cnt_d = 4'h0;
         st_oe_d = 1'b0;
      end else begin
         if (rise[P_CTL_SHIFT_CLOCK]) begin
            ctl_in_d = {ctl_in_q[CTL_W-2:0], lvl_d[P_DIN]};
            ctl_cnt_d = (ctl_cnt_q == CTL_LAST) ? 4'h0 : ctl_cnt_q + 4'h1;
            if (ctl_cnt_q == CTL_LAST) begin
               cmd_d = ctl_in_d;
               cmd_v_d = 1'b1;
               enh_d = ctl_in_d[CMD_ENH_BIT];
               clr = ctl_in_d[CMD_CLR_BIT];
            end
         end
         if (fall[P_CTL_SHIFT_CLOCK]) begin
            st_out_d = st_sh_q[CTL_W-1];
            st_sh_d = {st_sh_q[CTL_W-2:0], 1'b0};
         end
      end
      // A new event in the clearing cycle keeps the line asserted
      int_d = (int_q & ~clr) | LINE_EVENT | ovr_evt;
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctl_cnt_q <= 4'h0;
         ctl_in_q <= '0;
         st_sh_q <= '0;
         st_out_q <= 1'b0;
         st_oe_q <= 1'b0;
         cmd_q <= '0;
         cmd_v_q <= 1'b0;
         enh_q <= ENH_RST;
         int_q <= 1'b0;
      end else if (CE) begin
         ctl_cnt_q <= ctl_cnt_d;
         ctl_in_q <= ctl_in_d;
         st_sh_q <= st_sh_d;
         st_out_q <= st_out_d;
         st_oe_q <= st_oe_d;
         cmd_q <= cmd_d;
         cmd_v_q <= cmd_v_d;
         enh_q <= enh_d;
         int_q <= int_d;
      end
   end

   assign STATUS_SHIFT_OUTPUT = st_out_q;
   assign STATUS_SHIFT_OE = st_oe_q;
   assign INT_N_O = 1'b0;
   assign INT_N_OE = int_q;
   assign ENH_ACTIVE = enh_q;
   assign CTL_CMD = cmd_q;
   assign CTL_CMD_VALID = cmd_v_q;

   // ==========================================================
   // Checks
   a_stat_hiz: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && lvl_q[P_CS] && !fall[P_CS] |=> !STATUS_SHIFT_OE)
      else $error("status output driven while deselected");
   a_ctl_ignore: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && lvl_q[P_CS] && !fall[P_CS] |=> !CTL_CMD_VALID && ctl_cnt_q == 4'h0)
      else $error("control channel active while deselected");
   a_int_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && int_q && !clr |=> INT_N_OE)
      else $error("interrupt dropped without a clear");
   a_int_set: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && LINE_EVENT |=> INT_N_OE && !INT_N_O)
      else $error("event did not pull the interrupt low");
   a_bclk_dir: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE |=> BCLK_OE ==
      $past(master && stsp_mode_t'(MODE) == MODE_TE_MASTER))
      else $error("bit clock direction does not follow mode");
   a_lock_phase: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && master && LINE_FRAME |=> !BCLK_O && fcnt_q == fmt_last(fmt_q))
      else $error("bit clock not realigned to line frame");
   a_fs_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && master && bit_rise && fcnt_d == 8'h00 |=> TX_FRAME_SYNC_O)
      else $error("frame sync missing at frame start");
   a_rx_hiz: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && bit_rise && !frame_rx && rx_cnt_q == WORD_BITS
      |=> !RX_CHAN_DATA_OE)
      else $error("receive data still driven after last bit");
   a_dwin_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && !dwin_en |=> !D_CHAN_TX_WINDOW)
      else $error("D window pulsed while disabled");
   a_enh_cause: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && !enh_q && !cmd_v_d |=> !ENH_ACTIVE)
      else $error("enhanced mode set without a command");
   a_tx_push: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      CE && tx_done && !tx_pend_d |=> tx_pend_q && tx_word_q == $past(tx_sh_d))
      else $error("completed transmit word not queued");

   c_master_frame: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      master && frame_tx ##[1:300] tx_done);
   c_ctl_byte: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      cmd_v_q && cmd_q[CMD_ENH_BIT]);
   c_overrun: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
      ovr_evt);
endmodule : stsp_port
`default_nettype wire

// ===== pkg/stsp_pkg.sv
// Shared constants, types and format tables for the system port block
package stsp_pkg;

   // ==========================================================
   // Clocks and frame timing
   localparam int CORE_HZ = 100_000_000;
   localparam int FRAME_HZ = 8_000;
   localparam int BCLK_HZ_2048 = 2_048_000;
   localparam int BCLK_HZ_1536 = 1_536_000;
   localparam int BCLK_HZ_512 = 512_000;
   localparam int BCLK_HZ_256 = 256_000;
   localparam logic [7:0] HALF_2048 = 8'(CORE_HZ / (2 * BCLK_HZ_2048) - 1);
   localparam logic [7:0] HALF_1536 = 8'(CORE_HZ / (2 * BCLK_HZ_1536) - 1);
   localparam logic [7:0] HALF_512 = 8'(CORE_HZ / (2 * BCLK_HZ_512) - 1);
   localparam logic [7:0] HALF_256 = 8'(CORE_HZ / (2 * BCLK_HZ_256) - 1);
   localparam logic [7:0] LAST_2048 = 8'(BCLK_HZ_2048 / FRAME_HZ - 1);
   localparam logic [7:0] LAST_1536 = 8'(BCLK_HZ_1536 / FRAME_HZ - 1);
   localparam logic [7:0] LAST_512 = 8'(BCLK_HZ_512 / FRAME_HZ - 1);
   localparam logic [7:0] LAST_256 = 8'(BCLK_HZ_256 / FRAME_HZ - 1);

   // ==========================================================
   // Channel word: B1 [17:10], B2 [9:2], D [1:0], B1 first on the wire
   localparam int WORD_W = 18;
   localparam logic [4:0] WORD_BITS = 5'h12;
   localparam logic [4:0] LAST_BIT = 5'h11;
   localparam logic [7:0] D_FIRST = 8'h10;
   localparam logic [7:0] D_END = 8'h12;
   localparam logic [WORD_W-1:0] IDLE_WORD = 18'h3ffff;

   // ==========================================================
   // Pin synchroniser lanes
   localparam int NSYNC = 7;
   localparam int P_BCLK = 0;
   localparam int P_TXFS = 1;
   localparam int P_RXFS = 2;
   localparam int P_TXD = 3;
   localparam int P_CS = 4;
   localparam int P_CTL_SHIFT_CLOCK = 5;
   localparam int P_DIN = 6;
   localparam logic [NSYNC-1:0] SYNC_RST = 7'h10;

   // ==========================================================
   // Control channel
   localparam int CTL_W = 8;
   localparam logic [3:0] CTL_LAST = 4'h7;
   localparam int CMD_ENH_BIT = 0;
   localparam int CMD_CLR_BIT = 1;
   localparam logic ENH_RST = 1'h0;

   typedef enum logic [1:0] {
      MODE_TE_MASTER = 2'b00,
      MODE_TE_SLAVE = 2'b01,
      MODE_NT = 2'b10,
      MODE_LINECARD = 2'b11
   } stsp_mode_t;

   typedef enum logic [1:0] {
      FMT_2048 = 2'b00,
      FMT_1536 = 2'b01,
      FMT_512 = 2'b10,
      FMT_256 = 2'b11
   } stsp_fmt_t;

   function automatic logic [7:0] fmt_half(input stsp_fmt_t f);
      case (f)
         FMT_2048: fmt_half = HALF_2048;
         FMT_1536: fmt_half = HALF_1536;
         FMT_512: fmt_half = HALF_512;
         default: fmt_half = HALF_256;
      endcase
   endfunction : fmt_half

   function automatic logic [7:0] fmt_last(input stsp_fmt_t f);
      case (f)
         FMT_2048: fmt_last = LAST_2048;
         FMT_1536: fmt_last = LAST_1536;
         FMT_512: fmt_last = LAST_512;
         default: fmt_last = LAST_256;
      endcase
   endfunction : fmt_last

endpackage : stsp_pkg

// ===== pkg/stsp_stream_if.sv
// Valid/ready word carrier between the port logic and its buffer
`timescale 1ns/1ps
`default_nettype none
interface stsp_stream_if #(parameter int W = 18);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : stsp_stream_if
`default_nettype wire

// ===== verification/stsp_far.sv
// Far-side controller model for the system port
`timescale 1ns/1ps
`default_nettype none
module stsp_far (
   output logic bclk,
   output logic txfs,
   output logic rxfs,
   output logic txd,
   input wire logic rxd
);
   logic [17:0] got;
   logic busy;
   // ====
   // Link clock
   initial begin
      bclk = 1'b0;
      txfs = 1'b0;
      rxfs = 1'b0;
      txd = 1'b0;
      busy = 1'b0;
      #7;
      forever #40 bclk = ~bclk;
   end
   // Idle data toggles so a stale bit never passes as a real one
   always @(posedge bclk) if (!busy) txd <= ~txd;
   // ====
   // One frame: data moves at rise, rx bits taken at the next rise
   task automatic frame(input logic [17:0] w);
      @(posedge bclk);
      #1;
      busy = 1'b1;
      txfs = 1'b1;
      rxfs = 1'b1;
      for (int i = 17; i >= 0; i--) begin
         txd = w[i];
         @(posedge bclk);
         got[i] = rxd;
         #1;
         txfs = 1'b0;
         rxfs = 1'b0;
      end
      busy = 1'b0;
   endtask : frame
endmodule : stsp_far
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the system port with its far-side model
`timescale 1ns/1ps
`default_nettype none
module tb_top import stsp_pkg::*;;
   logic clk, rstn, ce, lfr, lev, cs_n, ctl_shift_clock, cdin, tx_ready, rx_valid;
   logic [1:0] mode, format;
   logic [2:0] maint;
   logic [17:0] rx_word, txw, q [4];
   logic bclk_o, bclk_oe, fso, fsoe, rxd, rxoe, dwin, st, stoe;
   logic into, intoe, txv, rxr, ovr, enh, cmdv;
   logic [7:0] cmd, s;
   logic bclk, txfs, rxfs, txd;
   int errors, num_checks, h, w, n, cmds;
   stsp_far far (.bclk(bclk), .txfs(txfs), .rxfs(rxfs), .txd(txd),
      .rxd(rxd));
   stsp_port uut (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .MODE(mode),
      .FORMAT(format), .LINE_FRAME(lfr), .LINE_EVENT(lev),
      .MAINT_IN(maint), .BCLK_I(bclk), .BCLK_O(bclk_o),
      .BCLK_OE(bclk_oe), .TX_FRAME_SYNC_I(txfs), .TX_FRAME_SYNC_O(fso),
      .TX_FRAME_SYNC_OE(fsoe), .RX_FRAME_SYNC_I(rxfs),
      .TX_CHAN_DATA_IN(txd), .RX_CHAN_DATA_OUT(rxd),
      .RX_CHAN_DATA_OE(rxoe), .D_CHAN_TX_WINDOW(dwin), .CS_N(cs_n),
      .CTL_SHIFT_CLOCK(ctl_shift_clock), .CTL_DATA_IN(cdin),
      .STATUS_SHIFT_OUTPUT(st), .STATUS_SHIFT_OE(stoe), .INT_N_O(into),
      .INT_N_OE(intoe), .TX_WORD(txw), .TX_VALID(txv),
      .TX_READY(tx_ready), .RX_WORD(rx_word), .RX_VALID(rx_valid),
      .RX_READY(rxr), .TX_OVERRUN(ovr), .ENH_ACTIVE(enh), .CTL_CMD(cmd),
      .CTL_CMD_VALID(cmdv));
   // ====
   // Shared tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Command strobes stand one cycle, so count them as they pass
   always @(negedge clk) if (cmdv === 1'b1) cmds++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   function automatic int half(input logic [1:0] f);
      int r [4] = '{2048000, 1536000, 512000, 256000};
      return 100_000_000 / (2 * r[f]);
   endfunction : half
   function automatic logic pick(input int k);
      return k == 0 ? bclk_o : (k == 1 ? fso : dwin);
   endfunction : pick
   // Counts cycles until the signal rises, then cycles it stays high
   task automatic hi_len(input int k);
      w = 0;
      n = 0;
      while (pick(k) !== 1'b1 && w < 20000) begin
         cyc(1);
         w++;
      end
      while (pick(k) === 1'b1 && n < 20000) begin
         cyc(1);
         n++;
      end
   endtask : hi_len
   task automatic take_tx(input logic [17:0] e);
      for (int i = 0; i < 400 && txv !== 1'b1; i++) cyc(1);
      chk(txv, 1'b1);
      chk(txw, e);
      tx_ready = 1'b1;
      cyc(1);
      tx_ready = 1'b0;
   endtask : take_tx
   task automatic give_rx(input logic [17:0] v);
      rx_word = v;
      rx_valid = 1'b1;
      for (int i = 0; i < 400 && rxr !== 1'b1; i++) cyc(1);
      cyc(1);
      rx_valid = 1'b0;
      chk(rxr, 1'b0);
      rx_word = ~v;
   endtask : give_rx
   task automatic frame_chk(input logic [17:0] t, input logic [17:0] r);
      far.frame(t);
      chk(far.got, r);
      cyc(8);
      chk(rxoe, 1'b0);
      take_tx(t);
   endtask : frame_chk
   task automatic ctl(input logic [7:0] c);
      cs_n = 1'b0;
      cyc(8);
      chk(stoe, 1'b1);
      for (int i = 7; i >= 0; i--) begin
         s[i] = st;
         cdin = c[i];
         cyc(6);
         ctl_shift_clock = 1'b1;
         cyc(6);
         ctl_shift_clock = ~ctl_shift_clock;
         cyc(6);
      end
      cs_n = 1'b1;
      cyc(6);
   endtask : ctl
   // ====
   // The whole sequence needs about 40 us; allow five times that
   initial begin
      #200_000;
      errors++;
      tally_and_finish();
   end
   // ====
   // Main sequence
   initial begin
      {rstn, ce, lfr, lev, ctl_shift_clock, cdin, tx_ready, rx_valid} = '0;
      {mode, format, maint, rx_word, cs_n} = {2'h1, 2'h0, 3'h0, 18'h0, 1'b1};
      void'($urandom(32'ha407));
      mode = 2'(1 + $urandom % 3);
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      ce = 1'b1;
      cyc(1);
      chk(bclk_oe, 1'b0);
      cyc(7);
      chk({bclk_oe, fsoe, enh}, 3'h0);
      frame_chk(18'h2aaaa, 18'h3ffff);
      repeat (4) frame_chk(18'($urandom), IDLE_WORD);
      for (int k = 0; k < 4; k++) begin
         q[k] = 18'($urandom);
         give_rx(~q[k]);
         frame_chk(q[k], ~q[k]);
      end
      // Receiver stalls: two buffered, one pending, the fourth dropped
      for (int k = 0; k < 4; k++) far.frame(q[k]);
      cyc(8);
      chk({ovr, intoe, into}, 3'h6);
      for (int k = 0; k < 3; k++) take_tx(q[k]);
      cyc(4);
      chk(txv, 1'b0);
      repeat (8) begin
         ctl_shift_clock = ~ctl_shift_clock;
         cdin = 1'b1;
         cyc(6);
      end
      chk({cmd, stoe}, 9'h0);
      chk(cmds, 0);
      maint = 3'($urandom);
      ctl(8'h03);
      chk(s, {3'b011, maint, mode});
      chk(cmds, 1);
      chk({cmd, enh, intoe, stoe}, 11'h01c);
      // A frozen block must not latch an event
      ce = 1'b0;
      lev = 1'b1;
      cyc(1);
      lev = 1'b0;
      ce = 1'b1;
      cyc(3);
      chk(intoe, 1'b0);
      lev = 1'b1;
      cyc(1);
      lev = 1'b0;
      cyc(3);
      chk(intoe, 1'b1);
      mode = 2'h0;
      format = 2'($urandom);
      h = half(format);
      cyc(4);
      chk({bclk_oe, fsoe}, 2'h3);
      lfr = 1'b1;
      cyc(1);
      lfr = 1'b0;
      hi_len(1);
      chk(w < h + 4, 1'b1);
      chk(n, 2 * h);
      hi_len(0);
      chk(n, h);
      hi_len(2);
      chk(n, 4 * h);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
